// *** rtl/sto_supervisor.sv ***
// Operation
// RULE_01 - With both inputs energised the function waits in standby and a start from the chosen source runs the drive.
// RULE_02 - De-energised inputs activate the function, stop the power stage so the motor coasts, and enter safe mode.
// RULE_03 - Safe mode is left only when no fault is pending and the inputs are energised again.
// RULE_04 - With the inputs de-energised the display shows the inhibit message.
// RULE_05 - A trip is shown on the display in place of the inhibit message.
// RULE_06 - Relay one opens while the function is active if its function setting is 13.
// RULE_07 - Relay two opens while the function is active if its function setting is 13.
// RULE_08 - A fault in either internal channel trips the drive with fault code 29.
// RULE_09 - The power stage is torque free less than 1 ms after the inputs drop.
// RULE_10 - The monitoring status follows less than 20 ms after the inputs drop.
// RULE_11 - A channel fault reaches the display and the healthy output in less than 20 ms.
// RULE_12 - Nothing that software writes can disable the function.
// RULE_13 - Once inputs return the drive may restart on its own if a start request still stands.
// RULE_14 - While inputs are de-energised start commands are ignored and inhibit stays shown.
// RULE_15 - The function is active when either synchronised channel reads de-energised.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sto_supervisor
    import sto_pkg::*;
#(
    parameter int DISC_CYC = sto_pkg::STO_DISC_CYC
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Safe torque input channels, high when energised
    input  wire logic             sto_ch_a,
    input  wire logic             sto_ch_b,
    // Start commands from the terminal source
    input  wire logic             term_start,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [31:0]           reg_rdata,
    // Drive outputs
    output logic                  pwm_enable,
    output logic                  relay_one_closed,
    output logic                  relay_two_closed,
    output logic                  drive_healthy,
    output logic                  sto_active,
    output sto_pkg::sto_disp_t    disp_sel,
    output logic [7:0]            fault_code,
    output logic                  irq
);
    import sto_pkg::*;

    // Refuse a mismatch time below one cycle or above half the monitor limit
    if (DISC_CYC < 1 || DISC_CYC > STO_MON_CYC / 2) begin : g_disc_check
        $error("DISC_CYC out of range");
    end

    // Two-stage synchronisers per channel
    logic [1:0] a_sync_q;
    logic [1:0] b_sync_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            a_sync_q <= 2'b00;
            b_sync_q <= 2'b00;
        end else begin
            a_sync_q <= {a_sync_q[0], sto_ch_a};
            b_sync_q <= {b_sync_q[0], sto_ch_b};
        end
    end
    logic start_meta_q;
    logic start_sync_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_meta_q <= 1'b0;
            start_sync_q <= 1'b0;
        end else begin
            start_meta_q <= term_start;
            start_sync_q <= start_meta_q;
        end
    end

    // Either channel low is enough; fail safe on any one channel
    logic inputs_off;
    assign inputs_off = !(a_sync_q[1] && b_sync_q[1]); // RULE_15

    // Software registers; none of them reaches the inhibit path
    logic [7:0] relay1_func_q;
    logic [7:0] relay2_func_q;
    logic [1:0] start_src_q;
    logic [STO_EV_W-1:0] irq_mask_q;
    logic       sw_run_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            relay1_func_q <= 8'h00;
            relay2_func_q <= 8'h00;
            start_src_q   <= 2'b00;
            irq_mask_q    <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                STO_REG_RELAY1:   relay1_func_q <= reg_wdata[7:0];
                STO_REG_RELAY2:   relay2_func_q <= reg_wdata[7:0];
                STO_REG_START:    start_src_q   <= reg_wdata[1:0];
                STO_REG_IRQ_MASK: irq_mask_q    <= reg_wdata[STO_EV_W-1:0];
                default: ;
            endcase
        end
    end

    logic ctl_wr;
    assign ctl_wr = reg_wr && (reg_addr == STO_REG_CTRL);

    // Run request: keypad/register start when source 0, terminal level otherwise
    logic run_req;
    always_comb begin
        if (start_src_q == 2'b00) begin
            run_req = sw_run_q;
        end else begin
            run_req = start_sync_q;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw_run_q <= 1'b0;
        end else if (ctl_wr && reg_wdata[STO_CTL_STOP]) begin
            sw_run_q <= 1'b0;
        end else if (ctl_wr && reg_wdata[STO_CTL_START]) begin
            sw_run_q <= 1'b1;
        end
    end

    // Channel discrepancy: the two channels disagree for too long
    logic [$clog2(STO_MON_CYC+1)-1:0] disc_cnt_q;
    logic fault_q;
    logic fault_reset;
    assign fault_reset = ctl_wr && reg_wdata[STO_CTL_FRESET];
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            disc_cnt_q <= '0;
        end else if (a_sync_q[1] == b_sync_q[1]) begin
            disc_cnt_q <= '0;
        end else if (disc_cnt_q < ($bits(disc_cnt_q))'(DISC_CYC)) begin
            disc_cnt_q <= disc_cnt_q + 1'b1;
        end
    end
    logic disc_hit;
    assign disc_hit = (disc_cnt_q == ($bits(disc_cnt_q))'(DISC_CYC));
    // Fault latch; a new detection wins over a reset in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else if (disc_hit) begin
            fault_q <= 1'b1; // RULE_08
        end else if (fault_reset) begin
            fault_q <= 1'b0;
        end
    end

    // Drive state machine
    sto_state_t state_q;
    sto_state_t state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            STO_ST_STANDBY: begin
                if (inputs_off || fault_q) begin
                    state_d = STO_ST_SAFE; // RULE_02
                end else if (run_req) begin
                    state_d = STO_ST_RUN; // RULE_01
                end
            end
            STO_ST_RUN: begin
                if (inputs_off || fault_q) begin
                    state_d = STO_ST_SAFE; // RULE_02
                end else if (!run_req) begin
                    state_d = STO_ST_STANDBY;
                end
            end
            STO_ST_SAFE: begin
                // Start is ignored here; a standing run request restarts afterwards
                if (!inputs_off && !fault_q) begin
                    state_d = STO_ST_STANDBY; // RULE_03 RULE_13 RULE_14
                end
            end
            default: state_d = STO_ST_SAFE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= STO_ST_SAFE;
        end else begin
            state_q <= state_d;
        end
    end

    // Power stage gate: directly from synchronised inputs, three cycles worst case
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_enable <= 1'b0;
        end else begin
            pwm_enable <= (state_q == STO_ST_RUN) && !inputs_off && !fault_q; // RULE_09 RULE_12
        end
    end

    // Status, relays, display and healthy output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sto_active       <= 1'b1;
            relay_one_closed <= 1'b0;
            relay_two_closed <= 1'b0;
            drive_healthy    <= 1'b0;
            fault_code       <= STO_CODE_NONE;
            disp_sel         <= STO_DISP_INHIBIT;
        end else begin
            sto_active       <= inputs_off; // RULE_10
            relay_one_closed <= !(inputs_off && relay1_func_q == STO_RELAY_FUNC); // RULE_06
            relay_two_closed <= !(inputs_off && relay2_func_q == STO_RELAY_FUNC); // RULE_07
            drive_healthy    <= !fault_q; // RULE_11
            fault_code       <= fault_q ? STO_FAULT_CODE : STO_CODE_NONE; // RULE_08
            if (fault_q) begin
                disp_sel <= STO_DISP_TRIP; // RULE_05 RULE_11
            end else if (inputs_off) begin
                disp_sel <= STO_DISP_INHIBIT; // RULE_04 RULE_14
            end else if (state_q == STO_ST_RUN) begin
                disp_sel <= STO_DISP_RUN;
            end else begin
                disp_sel <= STO_DISP_STOP;
            end
        end
    end

    // Sticky events; a read of the interrupt status clears, a new event wins
    logic inputs_off_q;
    logic fault_dly_q;
    logic [STO_EV_W-1:0] ev;
    logic [STO_EV_W-1:0] irq_stat_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            inputs_off_q <= 1'b1;
            fault_dly_q  <= 1'b0;
        end else begin
            inputs_off_q <= inputs_off;
            fault_dly_q  <= fault_q;
        end
    end
    always_comb begin
        ev = '0;
        ev[STO_EV_ACTIVE]  = inputs_off && !inputs_off_q;
        ev[STO_EV_CLEARED] = !inputs_off && inputs_off_q;
        ev[STO_EV_FAULT]   = fault_q && !fault_dly_q;
    end
    logic stat_rd;
    assign stat_rd = reg_rd && (reg_addr == STO_REG_IRQ_STAT);
    // A clearing read keeps any event of its own cycle
    logic [STO_EV_W-1:0] irq_stat_d;
    always_comb begin
        if (stat_rd) begin
            irq_stat_d = ev;
        end else begin
            irq_stat_d = irq_stat_q | ev;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end
    // Level output built from the next status so it drops together with a clearing read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                STO_REG_CTRL:     reg_rdata <= {31'h0000_0000, sw_run_q};
                STO_REG_STATUS:   reg_rdata <= {16'h0000, fault_code, 2'b00, state_q,
                                                a_sync_q[1], b_sync_q[1], fault_q, inputs_off};
                STO_REG_IRQ_STAT: reg_rdata <= {{(32-STO_EV_W){1'b0}}, irq_stat_q};
                STO_REG_IRQ_MASK: reg_rdata <= {{(32-STO_EV_W){1'b0}}, irq_mask_q};
                STO_REG_RELAY1:   reg_rdata <= {24'h00_0000, relay1_func_q};
                STO_REG_RELAY2:   reg_rdata <= {24'h00_0000, relay2_func_q};
                STO_REG_START:    reg_rdata <= {30'h0000_0000, start_src_q};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Checks
    torque_off_fast_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_09
        inputs_off |=> !pwm_enable)
        else $error("power stage still enabled with inputs off");
    run_needs_on_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_14
        (state_q == STO_ST_SAFE) && inputs_off |=> state_q == STO_ST_SAFE)
        else $error("left safe mode with inputs off");
    safe_exit_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
        (state_q == STO_ST_SAFE) && fault_q |=> state_q == STO_ST_SAFE)
        else $error("left safe mode with fault pending");
    inhibit_disp_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
        inputs_off && !fault_q |=> disp_sel == STO_DISP_INHIBIT)
        else $error("inhibit not shown");
    trip_disp_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
        fault_q |=> disp_sel == STO_DISP_TRIP && fault_code == STO_FAULT_CODE)
        else $error("trip not shown");
    relay_one_open_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
        inputs_off && relay1_func_q == STO_RELAY_FUNC |=> !relay_one_closed)
        else $error("relay one not opened");
    relay_two_open_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
        inputs_off && relay2_func_q == STO_RELAY_FUNC |=> !relay_two_closed)
        else $error("relay two not opened");
    monitor_follow_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
        $fell(a_sync_q[1]) |-> ##[1:2] sto_active)
        else $error("monitor status late");
    healthy_drop_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_11
        disc_hit |-> ##[1:2] !drive_healthy)
        else $error("healthy output not dropped");
    run_start_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
        state_q == STO_ST_STANDBY && run_req && !inputs_off && !fault_q
        |=> state_q == STO_ST_RUN ##1 pwm_enable || inputs_off || fault_q)
        else $error("start ignored in standby");
    // Fault code, safe mode exit, torque and interrupt checks
    code_on_trip_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
        disc_hit |-> ##2 fault_code == STO_FAULT_CODE)
        else $error("fault code not raised");
    safe_leave_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
        (state_q == STO_ST_SAFE) && !inputs_off && !fault_q |=> state_q == STO_ST_STANDBY)
        else $error("safe mode not left");
    torque_only_on_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
        pwm_enable |-> !sto_active && drive_healthy)
        else $error("torque allowed while function active");
    irq_level_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
        irq == |(irq_stat_q & $past(irq_mask_q)))
        else $error("interrupt level wrong");
endmodule : sto_supervisor
`default_nettype wire

// *** rtl/sto_pkg.sv ***
package sto_pkg;
    // Relay function code that ties a relay to the safe torque state
    localparam logic [7:0]  STO_RELAY_FUNC   = 8'h0D;
    // Fault code for an internal channel fault
    localparam logic [7:0]  STO_FAULT_CODE   = 8'h1D;
    localparam logic [7:0]  STO_CODE_NONE    = 8'h00;
    // Clock rate and response limits
    localparam int          STO_CLK_HZ       = 40_000_000;
    localparam int          STO_TORQUE_US    = 1000;
    localparam int          STO_MON_MS       = 20;
    localparam int          STO_TORQUE_CYC   = STO_CLK_HZ / 1_000_000 * STO_TORQUE_US;
    localparam int          STO_MON_CYC      = STO_CLK_HZ / 1000 * STO_MON_MS;
    // Default mismatch time between the two channels before a channel fault
    localparam int          STO_DISC_CYC     = 40_000;
    // Register map, word index times four
    localparam logic [7:0]  STO_REG_CTRL     = 8'h00;
    localparam logic [7:0]  STO_REG_STATUS   = 8'h04;
    localparam logic [7:0]  STO_REG_IRQ_STAT = 8'h08;
    localparam logic [7:0]  STO_REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0]  STO_REG_RELAY1   = 8'h10;
    localparam logic [7:0]  STO_REG_RELAY2   = 8'h14;
    localparam logic [7:0]  STO_REG_START    = 8'h18;
    // Control bits
    localparam int          STO_CTL_START    = 0;
    localparam int          STO_CTL_STOP     = 1;
    localparam int          STO_CTL_FRESET   = 2;
    // Interrupt event bits
    localparam int          STO_EV_ACTIVE    = 0;
    localparam int          STO_EV_CLEARED   = 1;
    localparam int          STO_EV_FAULT     = 2;
    localparam int          STO_EV_W         = 3;
    // Display selection
    typedef enum logic [1:0] {
        STO_DISP_STOP    = 2'b00,
        STO_DISP_RUN     = 2'b01,
        STO_DISP_INHIBIT = 2'b10,
        STO_DISP_TRIP    = 2'b11
    } sto_disp_t;
    // Drive state
    typedef enum logic [1:0] {
        STO_ST_STANDBY = 2'b00,
        STO_ST_RUN     = 2'b01,
        STO_ST_SAFE    = 2'b10
    } sto_state_t;
endpackage : sto_pkg

// *** sim/sto_relay_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behavioural safety relay: two forcibly guided contacts feeding the channels
module sto_relay_model #(
    parameter int LAG = 1
) (
    // Clock
    input  wire logic clk,
    // Commands from the bench
    input  wire logic energise,
    input  wire logic split,
    // Channel outputs, high when energised
    output logic      ch_a,
    output logic      ch_b
);
    logic [7:0] pipe_a_q;
    logic [7:0] pipe_b_q;

    // Contacts follow the command after LAG edges; split welds contact B open
    always_ff @(posedge clk) begin
        pipe_a_q <= {pipe_a_q[6:0], energise};
        pipe_b_q <= {pipe_b_q[6:0], energise & ~split};
    end

    // A slow relay is modelled by a larger LAG, never by a glitch
    assign ch_a = pipe_a_q[LAG-1];
    assign ch_b = pipe_b_q[LAG-1];
endmodule : sto_relay_model
`default_nettype wire

// *** sim/tb_safe_torque_off_supervisor.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_safe_torque_off_supervisor;
    import sto_pkg::*;
    localparam int DISC = 8;
    logic clk = 1'b0, sys_rst = 1'b1, term_start = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic energise = 1'b0, split = 1'b0, ch_a, ch_b;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic pwm_enable, relay_one_closed, relay_two_closed, drive_healthy, sto_active, irq;
    sto_disp_t disp_sel;
    logic [7:0] fault_code;
    int failures = 0, total_checks = 0;

    // 40 MHz drive clock
    always #12.5 clk = ~clk;

    sto_relay_model #(.LAG(1)) relay (.clk(clk), .energise(energise), .split(split),
        .ch_a(ch_a), .ch_b(ch_b));

    sto_supervisor #(.DISC_CYC(DISC)) dut (.clk(clk), .sys_rst(sys_rst), .sto_ch_a(ch_a),
        .sto_ch_b(ch_b), .term_start(term_start), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_enable(pwm_enable),
        .relay_one_closed(relay_one_closed), .relay_two_closed(relay_two_closed),
        .drive_healthy(drive_healthy), .sto_active(sto_active), .disp_sel(disp_sel),
        .fault_code(fault_code), .irq(irq));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle read; data stand only in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // Wait n edges, then let that edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // Drive outputs grouped: power, active flag, display
    task automatic outs(input logic p, input logic s, input sto_disp_t ds);
        chk(32'(pwm_enable), 32'(p));
        chk(32'(sto_active), 32'(s));
        chk(32'(disp_sel), 32'(ds));
    endtask : outs

    task automatic stop_test;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    // Watchdog far beyond the roughly 125 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        stop_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(3);
        outs(1'b0, 1'b1, STO_DISP_INHIBIT);
        wr(STO_REG_RELAY1, 32'(STO_RELAY_FUNC));
        wr(STO_REG_RELAY2, 32'(STO_RELAY_FUNC));
        wr(STO_REG_START, 32'h0000_0000);
        wr(STO_REG_IRQ_MASK, 32'h0000_0001);
        // Energise: standby, not running until a start arrives
        @(posedge clk) energise <= 1'b1;
        cyc(6);
        outs(1'b0, 1'b0, STO_DISP_STOP);
        chk(32'({relay_one_closed, relay_two_closed, drive_healthy}), 32'h0000_0007);
        rd(STO_REG_STATUS, d);
        chk(d, 32'h0000_000C);
        rd(STO_REG_IRQ_STAT, d);
        chk(d & 32'h0000_0002, 32'h0000_0002);
        cyc(2);
        chk(32'(irq), 32'h0000_0000);
        wr(STO_REG_CTRL, 32'h0000_0001);
        cyc(3);
        outs(1'b1, 1'b0, STO_DISP_RUN);
        // Inputs drop while running: torque removed within four edges
        @(posedge clk) energise <= 1'b0;
        cyc(4);
        outs(1'b0, 1'b1, STO_DISP_INHIBIT);
        chk(32'({relay_one_closed, relay_two_closed}), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0001);
        rd(STO_REG_STATUS, d);
        chk(d, 32'h0000_0021);
        rd(STO_REG_IRQ_STAT, d);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        // Start and setting changes while de-energised leave power, active flag and display unchanged
        wr(STO_REG_CTRL, 32'h0000_0001);
        wr(STO_REG_RELAY1, 32'h0000_0000);
        wr(STO_REG_START, 32'h0000_0003);
        wr(STO_REG_START, 32'h0000_0000);
        cyc(3);
        outs(1'b0, 1'b1, STO_DISP_INHIBIT);
        chk(32'(irq), 32'h0000_0000);
        // Relay one no longer tied to the function closes again; relay two stays open
        chk(32'({relay_one_closed, relay_two_closed}), 32'h0000_0002);
        // Run request still latched, so the drive restarts on its own
        @(posedge clk) energise <= 1'b1;
        cyc(8);
        outs(1'b1, 1'b0, STO_DISP_RUN);
        wr(STO_REG_CTRL, 32'h0000_0003);
        cyc(3);
        outs(1'b0, 1'b0, STO_DISP_STOP);
        // Channel B sticks open: active at once, channel fault after the mismatch time
        wr(STO_REG_IRQ_MASK, 32'h0000_0007);
        rd(STO_REG_IRQ_MASK, d);
        chk(d, 32'h0000_0007);
        @(posedge clk) split <= 1'b1;
        cyc(4);
        outs(1'b0, 1'b1, STO_DISP_INHIBIT);
        cyc(DISC + 6);
        chk(32'({drive_healthy, fault_code}), 32'(STO_FAULT_CODE));
        outs(1'b0, 1'b1, STO_DISP_TRIP);
        chk(32'(irq), 32'h0000_0001);
        rd(STO_REG_IRQ_STAT, d);
        chk(d & 32'h0000_0004, 32'h0000_0004);
        // Inputs back but fault pending: stays in safe mode
        @(posedge clk) split <= 1'b0;
        cyc(6);
        outs(1'b0, 1'b0, STO_DISP_TRIP);
        rd(STO_REG_STATUS, d);
        chk(d & 32'h0000_0030, 32'h0000_0020);
        wr(STO_REG_CTRL, 32'h0000_0004);
        cyc(4);
        outs(1'b0, 1'b0, STO_DISP_STOP);
        chk(32'({drive_healthy, fault_code}), 32'h0000_0100);
        // Terminal start source
        wr(STO_REG_START, 32'h0000_0001);
        @(posedge clk) term_start <= 1'b1;
        cyc(6);
        outs(1'b1, 1'b0, STO_DISP_RUN);
        rd(8'h1C, d);
        chk(d, 32'h0000_0000);
        // Reset in mid-run: outputs fall back, then standby once the inputs are seen
        @(posedge clk) sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        outs(1'b0, 1'b1, STO_DISP_INHIBIT);
        chk(32'({drive_healthy, relay_one_closed, irq}), 32'h0000_0000);
        cyc(5);
        outs(1'b0, 1'b0, STO_DISP_STOP);
        stop_test();
    end
endmodule : tb_safe_torque_off_supervisor
`default_nettype wire
